// file: test/test_pcm_voice_serial_port.sv
`timescale 1ns/1ps
module test_pcm_voice_serial_port;
   import voice_port_pkg::*;
   logic          core_clk, nrst, bit_clk, audio_frame_align, rx_data;
   logic          tx_data, tx_ready, tx_valid, rx_valid, align_error;
   voice_sample_t tx_sample, rx_sample;
   voice_sample_t rx_q[$];
   int            fails, comparisons, errs;
   logic [15:0]   prev;
   logic [15:0]   wv [5] = '{16'h8000, 16'h7fff, 16'h0001, 16'hfffe, 16'ha5c3};

   pcm_voice_serial_port dut (.core_clk(core_clk), .nrst(nrst), .bit_clk(bit_clk),
      .audio_frame_align(audio_frame_align), .rx_data(rx_data), .tx_data(tx_data),
      .tx_sample(tx_sample), .tx_ready(tx_ready), .tx_valid(tx_valid),
      .rx_sample(rx_sample), .rx_valid(rx_valid), .align_error(align_error));
   voice_codec_model codec (.bit_clk(bit_clk), .audio_frame_align(audio_frame_align),
      .rx_data(rx_data), .tx_data(tx_data));

   always #25 core_clk = ~core_clk;

   // sampled mid-cycle, away from the edge that launches these outputs
   always @(negedge core_clk) begin
      if (rx_valid === 1'b1) rx_q.push_back(rx_sample);
      if (align_error === 1'b1) errs++;
   end

   task automatic check(input logic [16:0] seen, input logic [16:0] exp);
      comparisons++;
      if (seen !== exp) begin
         fails++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check

   task automatic tally_and_finish();
      $display("fails=%0d comparisons=%0d", fails, comparisons);
      if (fails == 0 && comparisons > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : tally_and_finish

   task automatic offer(input logic [15:0] w);
      @(negedge core_clk);
      tx_sample = '{data: w, right: 1'b0};
      tx_valid = 1'b1;
      for (int n = 0; n < 400 && tx_ready !== 1'b1; n++) @(negedge core_clk);
      check(tx_ready, 1'b1);
      @(negedge core_clk);
      tx_valid = 1'b0;
   endtask : offer

   // five words each way; the word at skip is never offered, so zeros go out
   task automatic t_stream(input int skip);
      logic first;
      int   e0;
      first = ~audio_frame_align;
      e0 = errs;
      for (int k = 0; k < 6; k++) begin
         if (k < 5 && k != skip) offer(wv[k]);
         codec.half((k < 5) ? wv[k] : 16'h0000, 16, prev);
         if (k > 0) check(prev, (k - 1 == skip) ? 16'h0000 : wv[k-1]);
      end
      repeat (8) @(negedge core_clk);
      while (rx_q.size() > 5) void'(rx_q.pop_front());
      check(17'(rx_q.size()), 17'h5);
      for (int k = 0; k < 5 && rx_q.size() > 0; k++)
         check(rx_q.pop_front(), {wv[k], first ^ (k % 2 == 1)});
      check(17'(errs - e0), 17'h0);
   endtask : t_stream

   // a long half frame must be flagged once
   task automatic t_bad_align();
      int e0;
      e0 = errs;
      codec.half(16'h1111, 17, prev);
      codec.half(16'h0000, 16, prev);
      repeat (8) @(negedge core_clk);
      check(17'(errs - e0), 17'h1);
   endtask : t_bad_align

   initial begin
      core_clk = 1'b0;
      nrst = 1'b0;
      tx_valid = 1'b0;
      tx_sample = '0;
      repeat (12) @(posedge core_clk);
      @(negedge core_clk);
      nrst = 1'b1;
      @(negedge core_clk);
      check({tx_data, rx_valid, align_error, tx_ready}, 4'h1);
      t_stream(-1);
      t_stream(2);
      t_bad_align();
      t_stream(-1);
      tally_and_finish();
   end

   // three streams of about 39 us and the framing test of about 14 us fit well inside this span
   initial begin
      #1_000_000;
      fails++;
      tally_and_finish();
   end
endmodule : test_pcm_voice_serial_port

// file: test/voice_codec_model.sv
`timescale 1ns/1ps
module voice_codec_model (
   output logic      bit_clk,
   output logic      audio_frame_align,
   output logic      rx_data,
   input  wire logic tx_data
);
   logic        pend;
   logic [15:0] got;

   initial begin
      bit_clk           = 1'b1;
      audio_frame_align = 1'b0;
      rx_data           = 1'b0;
      pend              = 1'b0;
      got               = 16'h0000;
   end

   // the clock stands high between bursts, so the port must not count idle time
   // the align edge carries the lsb of the word before, then msb first
   task automatic half(input logic [15:0] w, input int len, output logic [15:0] prev);
      for (int i = 0; i < len; i++) begin
         #200 bit_clk = 1'b0;
         if (i == 0) begin
            audio_frame_align = ~audio_frame_align;
            rx_data = pend;
         end else if (i < 16) begin
            rx_data = w[16-i];
         end else begin
            rx_data = ~rx_data; // past the word the line carries no value
         end
         #200 bit_clk = 1'b1;
         if (i == 0) begin
            got[0] = tx_data;
            prev = got;
         end else if (i < 16) begin
            got[16-i] = tx_data;
         end
      end
      pend = w[0];
   endtask : half
endmodule : voice_codec_model

// file: verilog/pcm_voice_serial_port.sv
`timescale 1ns/1ps
module pcm_voice_serial_port
   import voice_port_pkg::*;
(
   input  wire logic          core_clk,
   input  wire logic          nrst,
   input  wire logic          bit_clk,
   input  wire logic          audio_frame_align,
   input  wire logic          rx_data,
   output logic               tx_data,
   input  wire voice_sample_t tx_sample,
   output logic               tx_ready,
   input  wire logic          tx_valid,
   output voice_sample_t      rx_sample,
   output logic               rx_valid,
   output logic               align_error
);
   voice_pins_in_t pins_raw;
   voice_pins_in_t pins;

   assign pins_raw = '{bit_clk: bit_clk, frame_align: audio_frame_align, rx_data: rx_data};

   pin_sync #(.WIDTH(3)) u_sync (
      .core_clk (core_clk),
      .nrst     (nrst),
      .async_in (pins_raw),
      .sync_out (pins)
   );

   logic       bclk_d;
   logic       align_d;
   logic       rise;
   logic       fall;
   logic [1:0] warm;
   logic [1:0] next_warm;
   logic       live;
   // side currently loaded into tx_shift
   logic       tx_side;
   logic       next_tx_side;

   // edges count only once the synchroniser and bclk_d hold real pin values;
   // otherwise a clock idling high gives a false rise right after reset
   assign live = (warm == 2'(SYNC_DEPTH + 1));
   assign rise = live & pins.bit_clk & ~bclk_d;
   assign fall = live & ~pins.bit_clk & bclk_d;

   // msb launch: the first fall after a new half has been seen
   function automatic logic msb_launch(input logic f, input logic seen, input logic lat, input logic side);
      return f && seen && (lat != side);
   endfunction : msb_launch

   // state
   logic                     next_bclk_d;
   logic                     align_seen;
   logic                     next_align_seen;
   logic                     align_lat;
   logic                     next_align_lat;
   logic [BIT_CNT_W-1:0]     rx_cnt;
   logic [BIT_CNT_W-1:0]     next_rx_cnt;
   logic [SAMPLE_W-1:0]      rx_shift;
   logic [SAMPLE_W-1:0]      next_rx_shift;
   logic [SAMPLE_W-1:0]      tx_shift;
   logic [SAMPLE_W-1:0]      next_tx_shift;
   logic [BIT_CNT_W-1:0]     tx_cnt;
   logic [BIT_CNT_W-1:0]     next_tx_cnt;
   voice_sample_t            tx_hold;
   voice_sample_t            next_tx_hold;
   logic                     tx_full;
   logic                     next_tx_full;
   logic                     next_tx_data;
   voice_sample_t            next_rx_sample;
   logic                     next_rx_valid;
   logic                     next_align_error;
   logic                     next_align_d;
   logic [BIT_CNT_W-1:0]     half_cnt;
   logic [BIT_CNT_W-1:0]     next_half_cnt;
   logic                     in_sync;
   logic                     next_in_sync;

   assign tx_ready = ~tx_full;

   always_comb begin
      next_bclk_d      = pins.bit_clk;
      next_warm        = live ? warm : warm + 2'h1;
      next_align_d     = align_d;
      next_align_seen  = align_seen;
      next_align_lat   = align_lat;
      next_rx_cnt      = rx_cnt;
      next_rx_shift    = rx_shift;
      next_tx_shift    = tx_shift;
      next_tx_cnt      = tx_cnt;
      next_tx_hold     = tx_hold;
      next_tx_full     = tx_full;
      next_tx_data     = tx_data;
      next_rx_sample   = rx_sample;
      next_rx_valid    = 1'b0;
      next_align_error = 1'b0;
      next_half_cnt    = half_cnt;
      next_in_sync     = in_sync;
      if (rise) begin
         // align sampled on rising edge, like the data
         next_align_d = pins.frame_align;
         // the lsb of a half lands on the rise that shows the next align edge
         if (align_seen && rx_cnt < 5'(SAMPLE_W)) begin
            next_rx_shift = {rx_shift[SAMPLE_W-2:0], pins.rx_data};
            next_rx_cnt   = rx_cnt + 5'(1);
            if (rx_cnt == 5'(SAMPLE_W-1)) begin
               // left half carried when align was low
               next_rx_sample = '{data: {rx_shift[SAMPLE_W-2:0], pins.rx_data}, right: align_lat};
               next_rx_valid  = 1'b1;
            end
         end
         if (pins.frame_align != align_d) begin
            // new half-frame: MSB comes on the next rising edge
            next_align_seen = 1'b1;
            next_align_lat  = pins.frame_align;
            next_rx_cnt     = '0;
            next_half_cnt   = 5'(1);
            // a half longer or shorter than 16 clocks breaks framing
            if (in_sync && half_cnt != 5'(HALF_BITS)) begin
               next_align_error = 1'b1;
            end
            next_in_sync = 1'b1;
         end else if (half_cnt <= 5'(HALF_BITS)) begin
            // stops one past a full half, so an overlong half still shows
            next_half_cnt = half_cnt + 5'(1);
         end
      end
      if (fall) begin
         if (msb_launch(fall, align_seen, align_lat, tx_side)) begin
            // the first fall after an align edge launches the MSB
            next_tx_shift = tx_full ? tx_hold.data : '0;
            next_tx_full  = 1'b0;
            next_tx_data  = tx_full ? tx_hold.data[SAMPLE_W-1] : 1'b0;
            next_tx_cnt   = 5'(1);
         end else if (tx_cnt != '0 && tx_cnt < 5'(SAMPLE_W)) begin
            next_tx_data = tx_shift[SAMPLE_W-1-tx_cnt];
            next_tx_cnt  = tx_cnt + 5'(1);
         end else begin
            // unused tail of the half-frame stays low
            next_tx_data = 1'b0;
         end
      end
      // a take in the load cycle must outlive the clear, so it is applied last
      if (tx_valid && !tx_full) begin
         next_tx_hold = tx_sample;
         next_tx_full = 1'b1;
      end
   end

   always_comb begin
      next_tx_side = tx_side;
      if (msb_launch(fall, align_seen, align_lat, tx_side)) begin
         next_tx_side = align_lat;
      end
   end

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         bclk_d      <= 1'b0;
         align_d     <= 1'b0;
         align_seen  <= 1'b0;
         align_lat   <= 1'b0;
         rx_cnt      <= '0;
         rx_shift    <= '0;
         tx_shift    <= '0;
         tx_cnt      <= '0;
         tx_hold     <= '0;
         tx_full     <= 1'b0;
         tx_data     <= 1'b0;
         rx_sample   <= '0;
         rx_valid    <= 1'b0;
         align_error <= 1'b0;
         half_cnt    <= '0;
         in_sync     <= 1'b0;
         tx_side     <= 1'b0;
         warm        <= 2'h0;
      end else begin
         bclk_d      <= next_bclk_d;
         align_d     <= next_align_d;
         align_seen  <= next_align_seen;
         align_lat   <= next_align_lat;
         rx_cnt      <= next_rx_cnt;
         rx_shift    <= next_rx_shift;
         tx_shift    <= next_tx_shift;
         tx_cnt      <= next_tx_cnt;
         tx_hold     <= next_tx_hold;
         tx_full     <= next_tx_full;
         tx_data     <= next_tx_data;
         rx_sample   <= next_rx_sample;
         rx_valid    <= next_rx_valid;
         align_error <= next_align_error;
         half_cnt    <= next_half_cnt;
         in_sync     <= next_in_sync;
         tx_side     <= next_tx_side;
         warm        <= next_warm;
      end
   end

   a_tx_changes_on_fall: assert property (@(posedge core_clk) disable iff (!nrst)
      $changed(tx_data) |-> $past(fall)) else $error("tx_data changed away from a bit clock fall");
   a_rx_word_full: assert property (@(posedge core_clk) disable iff (!nrst)
      rx_valid |-> $past(rx_cnt) == 5'(SAMPLE_W-1) && $past(rise)) else $error("rx word not 16 bits");
   a_rx_msb_first: assert property (@(posedge core_clk) disable iff (!nrst)
      rx_valid |-> rx_sample.data[0] == $past(pins.rx_data)) else $error("last received bit not lsb");
   a_rx_side_tag: assert property (@(posedge core_clk) disable iff (!nrst)
      rx_valid |-> rx_sample.right == $past(align_lat)) else $error("sample side tag wrong");
   a_align_restart: assert property (@(posedge core_clk) disable iff (!nrst)
      rise && pins.frame_align != align_d |=> rx_cnt == '0 && half_cnt == 5'(1)) else $error("align edge no restart");
   a_tx_msb_launch: assert property (@(posedge core_clk) disable iff (!nrst)
      msb_launch(fall, align_seen, align_lat, tx_side) && tx_full |=> tx_data == $past(tx_hold.data[SAMPLE_W-1]))
      else $error("tx msb not launched");
   a_load_frees: assert property (@(posedge core_clk) disable iff (!nrst)
      msb_launch(fall, align_seen, align_lat, tx_side) && tx_full |=> tx_ready)
      else $error("holding register not freed at load");
   a_half_len: assert property (@(posedge core_clk) disable iff (!nrst)
      align_error |-> $past(in_sync) && $past(half_cnt) != 5'(HALF_BITS)) else $error("false framing error");
   a_ready_drop: assert property (@(posedge core_clk) disable iff (!nrst)
      tx_valid && tx_ready |=> !tx_ready) else $error("holding register not taken");
   c_rx_word: cover property (@(posedge core_clk) disable iff (!nrst) rx_valid);
   c_tx_word: cover property (@(posedge core_clk) disable iff (!nrst)
      msb_launch(fall, align_seen, align_lat, tx_side) && tx_full);
   c_right_word: cover property (@(posedge core_clk) disable iff (!nrst) rx_valid && rx_sample.right);
   c_frame_err: cover property (@(posedge core_clk) disable iff (!nrst) align_error);
endmodule : pcm_voice_serial_port

// file: verilog/pin_sync.sv
`timescale 1ns/1ps
module pin_sync
   import voice_port_pkg::*;
#(
   parameter int WIDTH = 3
) (
   input  wire logic             core_clk,
   input  wire logic             nrst,
   input  wire logic [WIDTH-1:0] async_in,
   output logic      [WIDTH-1:0] sync_out
);
   logic [WIDTH-1:0] stage1;
   logic [WIDTH-1:0] stage2;

   // stage1 is read by stage2 only
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         stage1 <= '0;
         stage2 <= '0;
      end else begin
         stage1 <= async_in;
         stage2 <= stage1;
      end
   end

   assign sync_out = stage2;
endmodule : pin_sync

// file: verilog/voice_port_pkg.sv
package voice_port_pkg;
   localparam int SAMPLE_W   = 16;
   localparam int HALF_BITS  = 16;
   localparam int SYNC_DEPTH = 2;
   localparam int BIT_CNT_W  = 5;

   typedef struct packed {
      logic signed [SAMPLE_W-1:0] data;
      logic                       right;
   } voice_sample_t;

   typedef struct packed {
      logic bit_clk;
      logic frame_align;
      logic rx_data;
   } voice_pins_in_t;
endpackage : voice_port_pkg
